// [rsq_defines.vh]
// Purpose: constants for the reset sequencer
// Assumes: core_clk is the oscillator clock, one period per oscillator_period
// Notes:   counts are in oscillator periods
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH
`define RSQ_WDT_STRETCH     64
`define RSQ_CNT_W           5
`define RSQ_ALE_DELAY       32
`define RSQ_SYNC_CYCLES     2
`define RSQ_CFG_CYCLES      4
`define RSQ_VECTOR          24'hFF0000
`endif

// [rsq_stretch.v]
// Purpose: stretch a watchdog reset request to the full reset width
// Assumes: core_clk is the oscillator clock
// Notes:   5-bit counter ticks every second period, giving 64 periods
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"
module rsq_stretch #(
	parameter CNT_W = `RSQ_CNT_W
) (
	input  wire core_clk,   // Oscillator clock
	input  wire sys_rst,    // Async reset, active high
	input  wire clk_en,     // Clock enable
	input  wire trigger,    // Watchdog expiry pulse
	output wire stretch_on  // Stretched reset level
);
	reg [CNT_W-1:0] cnt_q;
	reg             half_q;
	reg             act_q;
	assign stretch_on = act_q | trigger;
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q  <= {CNT_W{1'b0}};
			half_q <= 1'b0;
			act_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (trigger)
			begin
				// Restart so a late expiry still gets a full width
				cnt_q  <= {CNT_W{1'b1}};
				half_q <= 1'b1;
				act_q  <= 1'b1;
			end
			else if (act_q)
			begin
				half_q <= ~half_q;
				if (!half_q)
				begin
					if (cnt_q == {CNT_W{1'b0}})
						act_q <= 1'b0;
					else
						cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule // rsq_stretch
`default_nettype wire

// [rsq_reset_sequencer.v]
// Purpose: merge reset sources, force pins, run the reset routine
// Assumes: rst_pin already Schmitt-filtered; inputs synchronous except rst_pin and sys_rst
// Notes:   special function register load is the sfr_load level to the core, held through ST_HOLD
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"
module rsq_reset_sequencer #(
	parameter ALE_DELAY  = `RSQ_ALE_DELAY,
	parameter SYNC_CYC   = `RSQ_SYNC_CYCLES,
	parameter CFG_CYC    = `RSQ_CFG_CYCLES
) (
	input  wire        core_clk,         // Oscillator clock
	input  wire        sys_rst,          // Async reset, active high (power-on)
	input  wire        clk_en,           // Freezes state while low
	input  wire        rst_pin,          // External reset pin, active high
	input  wire        hardware_watchdog_exp,       // Watchdog overflow pulse
	input  wire        counter_array_watchdog_exp,  // Counter-array match pulse
	input  wire        pof_wr,           // Software write strobe for flag
	input  wire        pof_wdata,        // Value written to flag
	input  wire        powerdown_set,    // Software sets powerdown_bit
	input  wire        idle_set,         // Software sets idle_bit
	output wire        pin_force,        // Async force of port pins to reset
	output wire        weak_pullup,      // Weak pull-up on strobes and ports
	output wire        core_reset,       // Synchronous internal reset
	output reg         sfr_load,         // Load registers with reset values
	output reg         cfg_fetch,        // Configuration fetch in progress
	output reg         vector_jump,      // Start execution at vector
	output reg  [23:0] vector_addr,      // Reset vector address
	output reg         ale_first,        // First address latch strobe pulse
	output reg         power_loss_flag,  // 1 after cold start
	output reg         powerdown_bit,    // Powerdown mode bit
	output reg         idle_bit          // Idle mode bit
);
	localparam ST_RUN  = 3'd0;
	localparam ST_HOLD = 3'd1;
	localparam ST_SYNC = 3'd2;
	localparam ST_CFG  = 3'd3;
	localparam ST_ALE  = 3'd4;

	wire       wdt_trig;
	wire       wdt_rst;
	wire       comb_rst;
	reg  [1:0] sync_q;
	reg        phase_q;
	reg        seen_q;
	reg  [2:0] state_q;
	reg  [5:0] cnt_q;

	assign wdt_trig = hardware_watchdog_exp | counter_array_watchdog_exp;

	rsq_stretch u_stretch (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.trigger    (wdt_trig),
		.stretch_on (wdt_rst)
	);

	// Watchdog and pin both force pins; only the pin and sys_rst drive the weak pull-up
	assign comb_rst    = rst_pin | wdt_rst;
	assign pin_force   = comb_rst | sys_rst;
	assign weak_pullup = rst_pin | sys_rst;
	assign core_reset  = (state_q != ST_RUN);

	// Pin level is asynchronous; two flops before use
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sync_q <= 2'b11;
		else if (clk_en)
			sync_q <= {sync_q[0], comb_rst};
	end

	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_q         <= 1'b0;
			seen_q          <= 1'b1;
			state_q         <= ST_HOLD;
			cnt_q           <= 6'h00;
			sfr_load        <= 1'b0;
			cfg_fetch       <= 1'b0;
			vector_jump     <= 1'b0;
			vector_addr     <= 24'h000000;
			ale_first       <= 1'b0;
			power_loss_flag <= 1'b1;
			powerdown_bit   <= 1'b0;
			idle_bit        <= 1'b0;
		end
		else if (clk_en)
		begin
			phase_q     <= ~phase_q;
			sfr_load    <= 1'b0;
			vector_jump <= 1'b0;
			ale_first   <= 1'b0;
			if (phase_q)
				seen_q <= sync_q[1];
			if (pof_wr)
				power_loss_flag <= pof_wdata;
			if (seen_q)
			begin
				powerdown_bit <= 1'b0;
				idle_bit      <= 1'b0;
			end
			else
			begin
				if (powerdown_set)
					powerdown_bit <= 1'b1;
				if (idle_set)
					idle_bit <= 1'b1;
			end
			case (state_q)
			ST_RUN:
				if (seen_q)
					state_q <= ST_HOLD;
			ST_HOLD:
			begin
				sfr_load  <= 1'b1;
				cfg_fetch <= 1'b0;
				if (!seen_q)
				begin
					state_q <= ST_SYNC;
					cnt_q   <= 6'h00;
				end
			end
			ST_SYNC:
			begin
				cnt_q <= cnt_q + 6'h01;
				if (cnt_q == SYNC_CYC[5:0] - 6'h01)
				begin
					state_q   <= ST_CFG;
					cfg_fetch <= 1'b1;
				end
			end
			ST_CFG:
			begin
				cnt_q <= cnt_q + 6'h01;
				if (cnt_q == SYNC_CYC[5:0] + CFG_CYC[5:0] - 6'h01)
				begin
					state_q   <= ST_ALE;
					cfg_fetch <= 1'b0;
				end
			end
			ST_ALE:
			begin
				cnt_q <= cnt_q + 6'h01;
				if (cnt_q == ALE_DELAY[5:0] - 6'h01)
				begin
					state_q     <= ST_RUN;
					ale_first   <= 1'b1;
					vector_jump <= 1'b1;
					vector_addr <= `RSQ_VECTOR;
				end
			end
			default:
				state_q <= ST_HOLD;
			endcase
			if (seen_q && state_q != ST_RUN && state_q != ST_HOLD)
				state_q <= ST_HOLD;
		end
	end
endmodule // rsq_reset_sequencer
`default_nettype wire

// [rsq_chk.sv]
// Purpose: port checks of the reset sequencer
// Assumes: one clock domain, sys_rst async high
// Notes: bound to every instance of the top
`timescale 1ns/1ps
`default_nettype none
module rsq_chk (
	input wire core_clk, sys_rst, clk_en, rst_pin, hardware_watchdog_exp, counter_array_watchdog_exp,
	input wire pof_wr, pof_wdata, pin_force, weak_pullup, core_reset, sfr_load, cfg_fetch,
	input wire vector_jump, ale_first, power_loss_flag, powerdown_bit, idle_bit,
	input wire [23:0] vector_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_pin_force: assert property (rst_pin |-> pin_force)
		else $error("pins not forced");
	a_weak_pull: assert property (rst_pin |-> weak_pullup)
		else $error("no weak pull-up");
	a_wdt_stretch: assert property ((hardware_watchdog_exp || counter_array_watchdog_exp) |-> ##[1:2] pin_force[*8])
		else $error("watchdog reset short");
	a_pin_core_rst: assert property (rst_pin[*6] |-> core_reset)
		else $error("pin reset not seen");
	a_hold_load: assert property (sfr_load |-> core_reset ##1 (!powerdown_bit && !idle_bit))
		else $error("mode bits kept");
	a_vector_addr: assert property (vector_jump |-> ##[0:1] vector_addr == 24'hFF0000)
		else $error("wrong vector");
	a_ale_pair: assert property (ale_first |-> vector_jump)
		else $error("strobe alone");
	a_cfg_lead: assert property ($fell(cfg_fetch) |-> ##[20:28] vector_jump)
		else $error("jump timing");
	a_pof_write: assert property ((pof_wr && clk_en) |=> power_loss_flag == $past(pof_wdata))
		else $error("flag write lost");
	a_warm_keep: assert property ((rst_pin && !pof_wr) |=> $stable(power_loss_flag))
		else $error("warm reset set flag");
	c_jump: cover property (vector_jump);
	c_hw: cover property (hardware_watchdog_exp);
	c_ca: cover property (counter_array_watchdog_exp);
endmodule // rsq_chk
bind rsq_reset_sequencer rsq_chk i_chk (.*);
`default_nettype wire

// [rsq_rst_src.sv]
// Purpose: external reset source on the reset pin
// Assumes: pin has a pull-down, so idle is low
// Notes: never drives the strobe pins
`timescale 1ns/1ps
`default_nettype none
module rsq_rst_src #(
	parameter MIN_HOLD = 64
) (
	input  wire logic       core_clk, // Oscillator clock
	input  wire logic       req,      // Start one reset pulse
	input  wire logic [7:0] extra,    // Hold beyond the minimum
	output wire logic       rst_pin   // Reset pin level
);
	logic [8:0] cnt_q = 9'h000;
	always @(posedge core_clk)
		if (req)
			cnt_q <= 9'(MIN_HOLD) + {1'b0, extra};
		else if (cnt_q != 9'h000)
			cnt_q <= cnt_q - 9'h001;
	assign rst_pin = (cnt_q != 9'h000);
endmodule // rsq_rst_src
`default_nettype wire

// [reset_sequencer_tb.sv]
// Purpose: self-checking bench of the reset sequencer
// Assumes: 100 ns clock
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module reset_sequencer_tb;
	logic core_clk = 1'b0, sys_rst = 1'b1, req = 1'b0, hw_exp = 1'b0, ca_exp = 1'b0;
	logic pof_wr = 1'b0, pof_wdata = 1'b0, pd_set = 1'b0, id_set = 1'b0, clk_en = 1'b1;
	logic [7:0] extra = 8'h10;
	wire rst_pin, pin_force, weak_pullup, core_reset, sfr_load, cfg_fetch, vector_jump, ale_first;
	wire power_loss_flag, powerdown_bit, idle_bit;
	wire [23:0] vector_addr;
	int bad_count = 0, checks = 0;
	always #50 core_clk = ~core_clk;
	rsq_rst_src i_src (.core_clk(core_clk), .req(req), .extra(extra), .rst_pin(rst_pin));
	rsq_reset_sequencer i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rst_pin(rst_pin),
		.hardware_watchdog_exp(hw_exp), .counter_array_watchdog_exp(ca_exp), .pof_wr(pof_wr),
		.pof_wdata(pof_wdata), .powerdown_set(pd_set), .idle_set(id_set), .pin_force(pin_force),
		.weak_pullup(weak_pullup), .core_reset(core_reset), .sfr_load(sfr_load), .cfg_fetch(cfg_fetch),
		.vector_jump(vector_jump), .vector_addr(vector_addr), .ale_first(ale_first),
		.power_loss_flag(power_loss_flag), .powerdown_bit(powerdown_bit), .idle_bit(idle_bit));
	task close_out;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task wait_jump;
		int n;
		n = 0;
		while (vector_jump !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n++;
		end
		`CHK(ale_first, 1'b1)
		@(negedge core_clk);
		`CHK(core_reset, 1'b0)
		`CHK(vector_addr, 24'hFF0000)
	endtask
	task t_cold;
		repeat (12) @(negedge core_clk);
		`CHK(pin_force, 1'b1)
		`CHK(power_loss_flag, 1'b1)
		@(posedge core_clk) sys_rst <= 1'b0;
		wait_jump();
		$display("cold start done");
	endtask
	task t_pin;
		@(posedge core_clk) {pof_wr, pd_set, id_set} <= 3'b111;
		@(posedge core_clk) {pof_wr, pd_set, id_set, req} <= 4'b0001;
		@(negedge core_clk);
		`CHK(power_loss_flag, 1'b0)
		`CHK({powerdown_bit, idle_bit}, 2'b11)
		@(posedge core_clk) req <= 1'b0;
		@(negedge core_clk);
		`CHK({pin_force, weak_pullup}, 2'b11)
		wait_jump();
		`CHK({power_loss_flag, powerdown_bit, idle_bit}, 3'b000)
		$display("pin reset done");
	endtask
	task t_wdt(input logic sel);
		@(posedge core_clk) {hw_exp, ca_exp} <= {~sel, sel};
		@(posedge core_clk) {hw_exp, ca_exp} <= 2'b00;
		@(negedge core_clk);
		`CHK({pin_force, weak_pullup}, 2'b10)
		repeat (40) @(negedge core_clk);
		`CHK(pin_force, 1'b1)
		wait_jump();
		$display("watchdog reset done");
	endtask
	task t_freeze;
		@(posedge core_clk) {clk_en, pof_wr, pof_wdata} <= 3'b011;
		@(posedge core_clk) {clk_en, pof_wr, pof_wdata} <= 3'b100;
		@(negedge core_clk);
		`CHK(power_loss_flag, 1'b0)
		$display("clock enable freeze done");
	endtask
	initial
	begin
		t_cold();
		t_pin();
		t_wdt(1'b0);
		t_wdt(1'b1);
		t_freeze();
		close_out();
	end
	initial
	begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		close_out();
	end
endmodule // reset_sequencer_tb
`default_nettype wire
